// >>> tb/incdec_skip_branch_or_exec_test.sv
// Bench for the execution unit
`default_nettype none
module incdec_skip_branch_or_exec_test
   import isd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk_sys_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0;
   isd_instr_type   instr_i = '0;
   logic [7:0]      file_rdata_i = 8'h00, pc_high_latch_i = 8'h00, w_reg_o;
   logic [6:0]      file_raddr_o;
   isd_file_wr_type file_wr_o;
   logic            zero_flag_o, pc_load_o, flush_o, busy_o;
   logic [12:0]     pc_o;
   int              err_count = 0, cmp_count = 0, cyc = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   isd_exec i_dut
   (
      .clk_sys_i       (clk_sys_i),
      .resetn_i        (resetn_i),
      .instr_valid_i   (instr_valid_i),
      .instr_i         (instr_i),
      .file_rdata_i    (file_rdata_i),
      .pc_high_latch_i (pc_high_latch_i),
      .file_raddr_o    (file_raddr_o),
      .file_wr_o       (file_wr_o),
      .w_reg_o         (w_reg_o),
      .zero_flag_o     (zero_flag_o),
      .pc_o            (pc_o),
      .pc_load_o       (pc_load_o),
      .flush_o         (flush_o),
      .busy_o          (busy_o)
   );
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 500)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic run(input isd_op_type op, input logic d, input logic [10:0] k, input logic [7:0] rd, input logic h);
      @(negedge clk_sys_i);
      instr_valid_i = 1'b1;
      instr_i = '{op, d, 7'h05, k};
      file_rdata_i = rd;
      @(negedge clk_sys_i);
      instr_valid_i = h;
   endtask : run
   task automatic t_inc_file;
      run(ISD_OP_INC_FILE, 1'b0, 11'h000, 8'h41, 1'b0);
      check(w_reg_o, 8'h42);
      check(zero_flag_o, 1'b0);
      check(file_wr_o.wr_en, 1'b0);
      check(file_raddr_o, 7'h05);
      run(ISD_OP_INC_FILE, 1'b1, 11'h000, 8'hFF, 1'b0);
      check(file_wr_o, 16'h8500);
      check(zero_flag_o, 1'b1);
      check(w_reg_o, 8'h42);
      $display("increment test done");
   endtask : t_inc_file
   task automatic t_skip(input isd_op_type op, input logic [7:0] rd,
                         input logic [7:0] rd_nz, input logic [7:0] res_nz);
      run(op, 1'b1, 11'h000, rd, 1'b1);
      check(file_wr_o, {1'b1, 7'h05, ISD_ZERO});
      check(flush_o, 1'b1);
      check(busy_o, 1'b1);
      check(zero_flag_o, 1'b1);
      @(negedge clk_sys_i);
      instr_valid_i = 1'b0;
      check(file_wr_o.wr_en, 1'b0);
      check(flush_o, 1'b0);
      run(op, 1'b0, 11'h000, rd_nz, 1'b0);
      check(w_reg_o, res_nz);
      check(file_wr_o.wr_en, 1'b0);
      check(flush_o, 1'b0);
      $display("skip test done");
   endtask : t_skip
   task automatic t_branch;
      pc_high_latch_i = 8'hF7;
      run(ISD_OP_BRANCH, 1'b0, 11'h2AA, 8'h00, 1'b1);
      check(pc_o, 13'h12AA);
      check(pc_load_o, 1'b1);
      check(flush_o, 1'b1);
      check(zero_flag_o, 1'b1);
      @(negedge clk_sys_i);
      instr_valid_i = 1'b0;
      check(pc_load_o, 1'b0);
      check(pc_o, 13'h12AA);
      $display("branch test done");
   endtask : t_branch
   task automatic t_or_lit;
      run(ISD_OP_OR_LIT, 1'b0, 11'h75A, 8'h00, 1'b0);
      check(w_reg_o, 8'h5B);
      check(zero_flag_o, 1'b0);
      $display("or test done");
   endtask : t_or_lit
   task automatic t_nop;
      run(ISD_OP_NONE, 1'b1, 11'h000, 8'h00, 1'b0);
      check(file_wr_o, 16'h0000);
      check(w_reg_o, 8'h5B);
      $display("nop test done");
   endtask : t_nop
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (10) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      t_inc_file();
      t_skip(ISD_OP_DEC_SKIP, 8'h01, 8'h02, 8'h01);
      t_skip(ISD_OP_INC_SKIP, 8'hFF, 8'h00, 8'h01);
      t_branch();
      t_or_lit();
      t_nop();
      give_verdict();
   end
endmodule : incdec_skip_branch_or_exec_test
`default_nettype wire

// >>> tb/isd_exec_sva.sv
// Checker for the execution unit
`default_nettype none
module isd_exec_sva
   import isd_pkg::*;
(
   input wire logic            clk_sys_i,
   input wire logic            resetn_i,
   input wire logic            instr_valid_i,
   input wire isd_instr_type   instr_i,
   input wire logic [7:0]      file_rdata_i,
   input wire logic [7:0]      pc_high_latch_i,
   input wire logic [6:0]      file_raddr_o,
   input wire isd_file_wr_type file_wr_o,
   input wire logic [7:0]      w_reg_o,
   input wire logic            zero_flag_o,
   input wire logic [12:0]     pc_o,
   input wire logic            pc_load_o,
   input wire logic            flush_o,
   input wire logic            busy_o
);
   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   logic        t, dk, ik;
   logic [1:0]  hi;
   logic [7:0]  rd;
   logic [10:0] lk;
   assign t = instr_valid_i && !flush_o;
   assign dk = t && instr_i.op == ISD_OP_DEC_SKIP;
   assign ik = t && instr_i.op == ISD_OP_INC_SKIP;
   always_ff @(posedge clk_sys_i)
   begin
      hi <= pc_high_latch_i[4:3];
      rd <= file_rdata_i;
      lk <= instr_i.literal;
   end
   sequence s_skip;
      flush_o && busy_o ##1 !flush_o;
   endsequence
   a_dec_res: assert property (dk && instr_i.dest_file |=> file_wr_o.wr_en && file_wr_o.data == rd - 8'h01)
      else $error("bad decrement");
   a_dec_skip: assert property (dk && file_rdata_i == 8'h01 |=> s_skip)
      else $error("no dec skip");
   a_no_skip: assert property (dk && file_rdata_i != 8'h01 || ik && file_rdata_i != 8'hFF |=> !flush_o)
      else $error("false skip");
   a_inc_res: assert property (ik && !instr_i.dest_file |=> w_reg_o == rd + 8'h01 && $stable(zero_flag_o))
      else $error("bad increment");
   a_inc_skip: assert property (ik && file_rdata_i == 8'hFF |=> s_skip)
      else $error("no inc skip");
   a_br_pc: assert property (t && instr_i.op == ISD_OP_BRANCH |=> pc_load_o && flush_o && pc_o == {hi, lk})
      else $error("bad branch");
   a_or_res: assert property (t && instr_i.op == ISD_OP_OR_LIT |=> w_reg_o == ($past(w_reg_o) | lk[7:0]))
      else $error("bad or");
   a_inc_zero: assert property (t && instr_i.op == ISD_OP_INC_FILE |=> zero_flag_o == (rd == 8'hFF))
      else $error("bad zero");
endmodule : isd_exec_sva
bind isd_exec isd_exec_sva u_sva
(
   .clk_sys_i       (clk_sys_i),
   .resetn_i        (resetn_i),
   .instr_valid_i   (instr_valid_i),
   .instr_i         (instr_i),
   .file_rdata_i    (file_rdata_i),
   .pc_high_latch_i (pc_high_latch_i),
   .file_raddr_o    (file_raddr_o),
   .file_wr_o       (file_wr_o),
   .w_reg_o         (w_reg_o),
   .zero_flag_o     (zero_flag_o),
   .pc_o            (pc_o),
   .pc_load_o       (pc_load_o),
   .flush_o         (flush_o),
   .busy_o          (busy_o)
);
`default_nettype wire

// >>> verilog/isd_exec.sv
// Execution unit for skip, increment, branch and OR-literal instructions
`default_nettype none
module isd_exec
   import isd_pkg::*;
(
   input  wire logic            clk_sys_i,
   input  wire logic            resetn_i,
   input  wire logic            instr_valid_i,
   input  wire isd_instr_type   instr_i,
   input  wire logic [7:0]      file_rdata_i,
   input  wire logic [7:0]      pc_high_latch_i,
   output logic [6:0]           file_raddr_o,
   output isd_file_wr_type      file_wr_o,
   output logic [7:0]           w_reg_o,
   output logic                 zero_flag_o,
   output logic [12:0]          pc_o,
   output logic                 pc_load_o,
   output logic                 flush_o,
   output logic                 busy_o
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic is_zero(input logic [7:0] v);
      return v == ISD_ZERO;
   endfunction : is_zero

   // Step a file value by one with 8-bit wrap
   function automatic logic [7:0] step_value(input logic [7:0] v, input logic down);
      logic [7:0] r;
      if (down)
         r = v - ISD_ONE;
      else
         r = v + ISD_ONE;
      return r;
   endfunction : step_value

   // Ops that read, step and route a file register
   function automatic logic is_step_op(input isd_op_type op);
      return (op == ISD_OP_DEC_SKIP) || (op == ISD_OP_INC_SKIP) || (op == ISD_OP_INC_FILE);
   endfunction : is_step_op

   // ***************************************************************
   // State
   // ***************************************************************
   logic [7:0]      w_reg;
   logic [7:0]      next_w_reg;
   logic            zero_flag;
   logic            next_zero_flag;
   logic [12:0]     pc;
   logic [12:0]     next_pc;
   logic            pc_load;
   logic            next_pc_load;
   logic            flush;
   logic            next_flush;
   isd_file_wr_type file_wr;
   isd_file_wr_type next_file_wr;

   // ***************************************************************
   // Decode
   // ***************************************************************
   logic            taken;
   logic            step_op;
   logic            skip_op;
   logic            branch_op;
   logic [7:0]      step_result;
   logic            step_zero;
   logic [7:0]      or_result;
   logic            or_zero;
   logic [12:0]     branch_target;

   // A slot presented while flush is high is the no-operation of a skip or branch
   assign taken         = instr_valid_i && !flush;
   assign step_op       = taken && is_step_op(instr_i.op);
   assign skip_op       = step_op && (instr_i.op != ISD_OP_INC_FILE);
   assign branch_op     = taken && (instr_i.op == ISD_OP_BRANCH);
   assign step_result   = step_value(file_rdata_i, instr_i.op == ISD_OP_DEC_SKIP);
   assign step_zero     = is_zero(step_result);
   assign or_result     = w_reg | instr_i.literal[7:0];
   assign or_zero       = is_zero(or_result);
   assign branch_target = {pc_high_latch_i[ISD_LATCH_HI:ISD_LATCH_LO], instr_i.literal};
   assign file_raddr_o  = instr_i.addr;

   // ***************************************************************
   // Working register and zero flag
   // ***************************************************************
   always_comb
   begin
      next_w_reg     = w_reg;
      next_zero_flag = zero_flag;
      if (taken)
      begin
         unique case (instr_i.op)
            ISD_OP_DEC_SKIP, ISD_OP_INC_SKIP:
            begin
               // Skip ops leave every flag alone
               if (!instr_i.dest_file)
               begin
                  next_w_reg = step_result;
               end
            end
            ISD_OP_INC_FILE:
            begin
               if (!instr_i.dest_file)
               begin
                  next_w_reg = step_result;
               end
               next_zero_flag = step_zero;
            end
            ISD_OP_OR_LIT:
            begin
               next_w_reg     = or_result;
               next_zero_flag = or_zero;
            end
            ISD_OP_BRANCH, ISD_OP_NONE:
            begin
               next_w_reg = w_reg;
            end
            default:
            begin
               next_w_reg = w_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         w_reg     <= ISD_W_RESET;
         zero_flag <= 1'b0;
      end
      else
      begin
         w_reg     <= next_w_reg;
         zero_flag <= next_zero_flag;
      end
   end

   // ***************************************************************
   // Branch target
   // ***************************************************************
   always_comb
   begin
      next_pc      = pc;
      next_pc_load = 1'b0;
      if (branch_op)
      begin
         next_pc      = branch_target;
         next_pc_load = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pc      <= ISD_PC_RESET;
         pc_load <= 1'b0;
      end
      else
      begin
         pc      <= next_pc;
         pc_load <= next_pc_load;
      end
   end

   // ***************************************************************
   // No-operation slot
   // ***************************************************************
   always_comb
   begin
      next_flush = 1'b0;
      if (skip_op)
      begin
         next_flush = step_zero;
      end
      else if (branch_op)
      begin
         next_flush = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         flush <= 1'b0;
      end
      else
      begin
         flush <= next_flush;
      end
   end

   // ***************************************************************
   // File register write
   // ***************************************************************
   always_comb
   begin
      next_file_wr = '0;
      if (step_op && instr_i.dest_file)
      begin
         next_file_wr.wr_en = 1'b1;
         next_file_wr.addr  = instr_i.addr;
         next_file_wr.data  = step_result;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         file_wr <= '0;
      end
      else
      begin
         file_wr <= next_file_wr;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign w_reg_o     = w_reg;
   assign zero_flag_o = zero_flag;
   assign pc_o        = pc;
   assign pc_load_o   = pc_load;
   assign flush_o     = flush;
   assign file_wr_o   = file_wr;
   assign busy_o      = flush;

endmodule : isd_exec
`default_nettype wire

// >>> verilog/isd_pkg.sv
// Package of constants and types for the instruction execution block
// Functional notes
// - Decrement-and-skip subtracts one from file register 0..127 and writes W when d is 0, else the file register.
// - A zero decrement-and-skip result discards the next instruction for a no-operation, taking two cycles, no flags.
// - A non-zero result of either skip instruction lets the next instruction run with no extra cycle.
// - Increment-and-skip adds one to the file register, routes the result by d, and leaves all flags unchanged.
// - A zero increment-and-skip result replaces the next instruction with a no-operation, taking two cycles.
// - The branch loads its 11-bit literal into PC bits 10:0 and latch bits 4:3 into PC bits 12:11.
// - The branch is always taken, takes two cycles and leaves all flags unchanged.
// - OR-literal ORs W with an 8-bit literal, stores the result in W and updates the zero flag.
// - Plain increment adds one to the file register, routes the result by d and updates the zero flag.
`default_nettype none
package isd_pkg;
   // ***************************************************************
   // Widths and fields
   // ***************************************************************
   localparam int ISD_DATA_W  = 8;
   localparam int ISD_ADDR_W  = 7;
   localparam int ISD_PC_W    = 13;
   localparam int ISD_LIT_W   = 11;
   localparam int ISD_LATCH_LO = 3;
   localparam int ISD_LATCH_HI = 4;
   localparam logic [7:0]  ISD_ONE     = 8'h01;
   localparam logic [7:0]  ISD_ZERO    = 8'h00;
   localparam logic [7:0]  ISD_W_RESET = 8'h00;
   localparam logic [12:0] ISD_PC_RESET = 13'h0000;

   // ***************************************************************
   // Operations
   // ***************************************************************
   typedef enum logic [2:0]
   {
      ISD_OP_NONE,
      ISD_OP_DEC_SKIP,
      ISD_OP_INC_SKIP,
      ISD_OP_BRANCH,
      ISD_OP_OR_LIT,
      ISD_OP_INC_FILE
   } isd_op_type;

   typedef struct packed
   {
      isd_op_type  op;
      logic        dest_file;
      logic [6:0]  addr;
      logic [10:0] literal;
   } isd_instr_type;

   typedef struct packed
   {
      logic       wr_en;
      logic [6:0] addr;
      logic [7:0] data;
   } isd_file_wr_type;
endpackage : isd_pkg
`default_nettype wire
